// file: serp_pkg.sv
`default_nettype none
package serp_pkg;
  // system clock and timing
  localparam int CLK_NS     = 4;
  localparam int T_WR_NS    = 5_000_000;
  localparam int WR_CYC     = T_WR_NS / CLK_NS;
  localparam int SCL_PER_NS = 64;
  localparam int SCL_HALF   = (SCL_PER_NS / 2) / CLK_NS;
  // array geometry
  localparam int ADDR_W     = 11;
  localparam int MEM_BYTES  = 2048;
  localparam int PAGE_BYTES = 16;
  localparam int PG_LSB     = 4;
  // bit counter marks within one nine-clock byte slot
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] END_BIT = 4'h9;
  // reset values
  localparam logic [10:0] ADDR_RST = 11'h000;
  // device-type code, value arbitrary
  localparam logic [3:0] DEV_CODE_DFLT = 4'h5;
  // controller answer width: nack flag plus byte
  localparam int RSP_W = 9;
endpackage
`default_nettype wire

// file: serp_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface serp_link_if;
  logic scl_c_o;
  logic scl_c_oe;
  logic sda_c_o;
  logic sda_c_oe;
  logic sda_d_o;
  logic sda_d_oe;
  wire  scl;
  wire  sda;
  // open-drain wires: pulled high unless someone drives low
  assign scl = ~(scl_c_oe & ~scl_c_o);
  assign sda = ~((sda_c_oe & ~sda_c_o) | (sda_d_oe & ~sda_d_o));
  modport ctl (output scl_c_o, scl_c_oe, sda_c_o, sda_c_oe, input scl, sda);
  modport dev (output sda_d_o, sda_d_oe, input scl, sda);
endinterface
`default_nettype wire

// file: serp_buf2.sv
`timescale 1ns/100ps
`default_nettype none
module serp_buf2 #(
  parameter int W = serp_pkg::RSP_W
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] ent_q [2];
  logic         wr_q;
  logic         rd_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  // handshakes
  assign in_ready  = cnt_q != 2'h2;
  assign out_valid = cnt_q != 2'h0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = ent_q[rd_q];

  // storage needs no reset; only the counters say what is valid
  always_ff @(posedge clk_sys) begin
    if (push) begin
      ent_q[wr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // serp_buf2
`default_nettype wire

// file: serp_ctl.sv
`timescale 1ns/100ps
`default_nettype none
module serp_ctl #(
  parameter int HALF = serp_pkg::SCL_HALF
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // link
  serp_link_if.ctl        link,
  // byte command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_rd,
  input  wire logic       cmd_nack,
  input  wire logic [7:0] cmd_data,
  // byte answer
  output logic            rsp_valid,
  input  wire logic       rsp_ready,
  output logic [7:0]      rsp_data,
  output logic            rsp_nack
);
  typedef enum logic [1:0] {C_IDLE, C_STA, C_BIT, C_STO} serp_cst_e;
  serp_cst_e   st_q;
  logic [1:0]  ph_q;
  logic [15:0] tmr_q;
  logic [3:0]  bitn_q;
  logic [7:0]  tx_q;
  logic [7:0]  rx_q;
  logic        ackin_q;
  logic        stop_q;
  logic        rd_q;
  logic        nack_q;
  logic        scl_oe_q;
  logic        sda_oe_q;
  logic        push_q;
  logic        sda_m;
  logic        sda_s;
  logic        step;
  logic        in_ready;
  logic        take;

  assign link.scl_c_o  = 1'b0;
  assign link.sda_c_o  = 1'b0;
  assign link.scl_c_oe = scl_oe_q;
  assign link.sda_c_oe = sda_oe_q;
  assign step      = tmr_q == 16'(HALF - 1);
  // a command waits while answers back up, so the clock stalls too
  assign cmd_ready = (st_q == C_IDLE) & in_ready & ~push_q;
  assign take      = cmd_valid & cmd_ready;

  // data line from the wire, two flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m <= link.sda;
      sda_s <= sda_m;
    end
  end

  // half-period timer of the divided link clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) tmr_q <= 16'h0000;
    else if (st_q == C_IDLE || step) tmr_q <= 16'h0000;
    else tmr_q <= tmr_q + 16'h0001;
  end

  // bus sequencer: start, nine bit slots, stop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q     <= C_IDLE;
      ph_q     <= 2'h0;
      bitn_q   <= 4'h0;
      tx_q     <= 8'h00;
      rx_q     <= 8'h00;
      ackin_q  <= 1'b1;
      stop_q   <= 1'b0;
      rd_q     <= 1'b0;
      nack_q   <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        C_IDLE: begin
          if (take) begin
            tx_q   <= cmd_data;
            stop_q <= cmd_stop;
            rd_q   <= cmd_rd;
            nack_q <= cmd_nack;
            ph_q   <= 2'h0;
            bitn_q <= 4'h0;
            if (cmd_start) begin
              st_q     <= C_STA;
              sda_oe_q <= 1'b0;
            end else begin
              st_q     <= C_BIT;
              scl_oe_q <= 1'b1;
              sda_oe_q <= ~cmd_rd & ~cmd_data[7];
            end
          end
        end
        C_STA: if (step) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: scl_oe_q <= 1'b0;
            2'h1: sda_oe_q <= 1'b1;
            default: begin
              scl_oe_q <= 1'b1;
              st_q     <= C_BIT;
              ph_q     <= 2'h0;
              sda_oe_q <= ~rd_q & ~tx_q[7];
            end
          endcase
        end
        C_BIT: if (step) begin
          case (ph_q)
            2'h0: begin
              scl_oe_q <= 1'b0;
              ph_q     <= 2'h1;
            end
            2'h1: begin
              scl_oe_q <= 1'b1;
              if (bitn_q == serp_pkg::ACK_BIT) begin
                ackin_q  <= sda_s;
                sda_oe_q <= 1'b0;
                ph_q     <= 2'h2;
              end else begin
                rx_q   <= {rx_q[6:0], sda_s};
                bitn_q <= bitn_q + 4'h1;
                tx_q   <= {tx_q[6:0], 1'b0};
                ph_q   <= 2'h0;
                if (bitn_q == 4'h7) sda_oe_q <= rd_q & ~nack_q;
                else sda_oe_q <= ~rd_q & ~tx_q[6];
              end
            end
            default: begin
              ph_q <= 2'h0;
              if (stop_q) begin
                st_q     <= C_STO;
                sda_oe_q <= 1'b1;
              end else begin
                st_q <= C_IDLE;
              end
            end
          endcase
        end
        C_STO: if (step) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: scl_oe_q <= 1'b0;
            2'h1: sda_oe_q <= 1'b0;
            default: begin
              st_q <= C_IDLE;
              ph_q <= 2'h0;
            end
          endcase
        end
        default: st_q <= C_IDLE;
      endcase
    end
  end

  // one answer per byte, queued once its ack slot is over
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) push_q <= 1'b0;
    else push_q <= (st_q == C_BIT) & step & (ph_q == 2'h2);
  end

  serp_buf2 #(.W(serp_pkg::RSP_W)) serp_buf2_i (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .in_valid (push_q),
    .in_ready (in_ready),
    .in_data  ({ackin_q, rx_q}),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data ({rsp_nack, rsp_data})
  );
endmodule // serp_ctl
`default_nettype wire

// file: serp_dev.sv
`timescale 1ns/100ps
`default_nettype none
module serp_dev #(
  parameter int         WR_CYC   = serp_pkg::WR_CYC,
  parameter logic [3:0] DEV_CODE = serp_pkg::DEV_CODE_DFLT  // value arbitrary
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // link
  serp_link_if.dev  link,
  // write protect pin
  input  wire logic wp,
  // status
  output logic      busy
);
  typedef enum logic [2:0] {D_IDLE, D_DEV, D_WADR, D_WDAT, D_RDAT} serp_dst_e;
  localparam int PB = serp_pkg::PAGE_BYTES;

  logic [7:0]  mem_q [serp_pkg::MEM_BYTES];
  logic [7:0]  pg_dat_q [PB];
  logic [PB-1:0] pg_val_q;
  serp_dst_e   st_q;
  logic [3:0]  bitc_q;
  logic [7:0]  sh_q;
  logic [7:0]  tx_q;
  logic        rd_q;
  logic        mack_q;
  logic        drv_q;
  logic [10:0] addr_q;
  logic        busy_q;
  logic [20:0] bcnt_q;
  logic        scl_m;
  logic        scl_s;
  logic        scl_p;
  logic        sda_m;
  logic        sda_s;
  logic        sda_p;
  logic        wp_m;
  logic        wp_s;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        live;
  logic        rx_st;
  logic        rx_fin;
  logic        dev_hit;
  logic        wadr_fin;
  logic        wdat_fin;
  logic        ack_end;
  logic        ld;
  logic        commit;

  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = drv_q;
  assign busy          = busy_q;

  // pins cross into the system clock through two flops each
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      wp_m  <= 1'b1;
      wp_s  <= 1'b1;
    end else begin
      scl_m <= link.scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= link.sda;
      sda_s <= sda_m;
      sda_p <= sda_s;
      wp_m  <= wp;
      wp_s  <= wp_m;
    end
  end

  // link events; data changes while the clock is high mark start or stop
  assign rise  = scl_s & ~scl_p;
  assign fall  = ~scl_s & scl_p;
  assign start = scl_s & scl_p & sda_p & ~sda_s;
  assign stop  = scl_s & scl_p & ~sda_p & sda_s;
  // programming blinds the device to the whole bus
  assign live  = ~busy_q;
  assign rx_st = (st_q == D_DEV) | (st_q == D_WADR) | (st_q == D_WDAT);
  assign rx_fin   = live & ~start & ~stop & fall & rx_st & (bitc_q == serp_pkg::ACK_BIT);
  assign dev_hit  = sh_q[7:4] == DEV_CODE;
  assign wadr_fin = rx_fin & (st_q == D_WADR);
  assign wdat_fin = rx_fin & (st_q == D_WDAT);
  assign ack_end  = live & ~start & ~stop & fall & (bitc_q == serp_pkg::END_BIT);
  // next byte out: after a read address, or after a controller ack
  assign ld = ack_end & (((st_q == D_DEV) & rd_q) | ((st_q == D_RDAT) & mack_q));
  // protected array: bytes are acked but the stop programs nothing
  assign commit = live & stop & (st_q == D_WDAT) & (|pg_val_q) & ~wp_s;

  // protocol state, bit slots and the data line drive
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q   <= D_IDLE;
      bitc_q <= 4'h0;
      sh_q   <= 8'h00;
      tx_q   <= 8'h00;
      rd_q   <= 1'b0;
      mack_q <= 1'b0;
      drv_q  <= 1'b0;
    end else if (!live) begin
      st_q   <= D_IDLE;
      bitc_q <= 4'h0;
      drv_q  <= 1'b0;
    end else if (start) begin
      st_q   <= D_DEV;
      bitc_q <= 4'h0;
      drv_q  <= 1'b0;
    end else if (stop) begin
      st_q  <= D_IDLE;
      drv_q <= 1'b0;
    end else if (st_q != D_IDLE) begin
      if (rise && bitc_q <= serp_pkg::ACK_BIT) begin
        bitc_q <= bitc_q + 4'h1;
        if (rx_st && bitc_q < serp_pkg::ACK_BIT) sh_q <= {sh_q[6:0], sda_s};
        if (st_q == D_RDAT && bitc_q == serp_pkg::ACK_BIT) mack_q <= ~sda_s;
      end
      if (fall) begin
        if (bitc_q == serp_pkg::ACK_BIT) begin
          if (rx_st) begin
            if (st_q != D_DEV || dev_hit) begin
              drv_q <= 1'b1;
            end else begin
              st_q <= D_IDLE;
            end
            if (st_q == D_DEV) rd_q <= sh_q[0];
          end else begin
            drv_q <= 1'b0;
          end
        end else if (bitc_q == serp_pkg::END_BIT) begin
          bitc_q <= 4'h0;
          drv_q  <= ld ? ~mem_q[addr_q][7] : 1'b0;
          tx_q   <= mem_q[addr_q];
          case (st_q)
            D_DEV:   st_q <= rd_q ? D_RDAT : D_WADR;
            D_WADR:  st_q <= D_WDAT;
            D_WDAT:  st_q <= D_WDAT;
            D_RDAT:  st_q <= mack_q ? D_RDAT : D_IDLE;
            default: st_q <= D_IDLE;
          endcase
        end else if (st_q == D_RDAT && bitc_q != 4'h0) begin
          tx_q  <= {tx_q[6:0], 1'b0};
          drv_q <= ~tx_q[6];
        end
      end
    end
  end

  // address counter survives between transfers, only reset clears it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_q <= serp_pkg::ADDR_RST;
    end else if (rx_fin && st_q == D_DEV && dev_hit) begin
      addr_q[10:8] <= sh_q[3:1];
    end else if (wadr_fin) begin
      addr_q[7:0] <= sh_q;
    end else if (wdat_fin) begin
      addr_q[3:0] <= addr_q[3:0] + 4'h1;
    end else if (ld) begin
      addr_q <= addr_q + 11'h001;
    end
  end

  // page buffer; a wrapped offset simply rewrites its slot
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pg_val_q <= '0;
    end else if (wadr_fin || (live && stop)) begin
      pg_val_q <= '0;
    end else if (wdat_fin) begin
      pg_val_q[addr_q[3:0]] <= 1'b1;
    end
  end

  // page data holds no control meaning, so it needs no reset
  always_ff @(posedge clk_sys) begin
    if (wdat_fin) begin
      pg_dat_q[addr_q[3:0]] <= sh_q;
    end
  end

  // array update happens at once; the timed cycle only holds the bus off
  always_ff @(posedge clk_sys) begin
    if (commit) begin
      for (int i = 0; i < PB; i++) begin
        if (pg_val_q[i]) mem_q[{addr_q[10:4], 4'(i)}] <= pg_dat_q[i];
      end
    end
  end

  // programming timer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      bcnt_q <= 21'h000000;
    end else if (commit) begin
      busy_q <= 1'b1;
      bcnt_q <= 21'(WR_CYC - 1);
    end else if (busy_q) begin
      if (bcnt_q == 21'h000000) busy_q <= 1'b0;
      else bcnt_q <= bcnt_q - 21'h000001;
    end
  end
endmodule // serp_dev
`default_nettype wire

// file: serp_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module serp_link_assertions #(
  parameter int WR_CYC = serp_pkg::WR_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link signals
  input wire logic scl_c_o,
  input wire logic sda_c_o,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda,
  // device pins
  input wire logic wp,
  input wire logic busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] busy_cnt_q;
  logic        sda_q;
  logic [7:0]  since_stop_q;
  // length of the running programming cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      busy_cnt_q <= '0;
    else
      busy_cnt_q <= busy ? busy_cnt_q + 32'h1 : '0;
  end
  // cycles since the last stop, saturating so an old stop never looks recent
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_q        <= 1'b1;
      since_stop_q <= 8'hFF;
    end else begin
      sda_q <= sda;
      if (scl && sda && !sda_q)
        since_stop_q <= 8'h00;
      else if (since_stop_q != 8'hFF)
        since_stop_q <= since_stop_q + 8'h01;
    end
  end
  property p_od_zero;
    !scl_c_o && !sda_c_o && !sda_d_o;
  endproperty
  a_od_zero: assert property (p_od_zero) else $error("open-drain drive not low");
  property p_busy_quiet;
    busy |-> !sda_d_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("device drove while busy");
  property p_busy_len;
    $fell(busy) |-> busy_cnt_q >= WR_CYC && busy_cnt_q <= WR_CYC + 2;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("programming time wrong");
  property p_busy_stop;
    $rose(busy) |-> since_stop_q <= 8'h08;
  endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("programming without stop");
  // the device only moves its data line while the clock is low
  property p_dev_edge;
    $changed(sda_d_oe) |-> !scl && !$past(scl);
  endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("device data moved in clock high");
  property p_ack_hold;
    $rose(scl) && sda_d_oe |-> sda_d_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low bit not held over clock high");
  property p_wp_block;
    wp && $past(wp, 4) |-> !$rose(busy);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("programming while protected");
  property p_scl_high;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("link clock high too short");
  c_prog: cover property ($rose(busy));
  c_ack: cover property ($rose(sda_d_oe));
  c_poll: cover property (busy && $rose(scl));
endmodule // serp_link_assertions
`default_nettype wire

// file: serial_eeprom_rw_protocol_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_rw_protocol_tb;
  localparam int         WR_CYC = 400;   // longer than one poll byte, so polls see refusal
  localparam logic [3:0] DEV    = 4'h6;  // value arbitrary
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       wp = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_start = 1'b0;
  logic       cmd_stop = 1'b0;
  logic       cmd_rd = 1'b0;
  logic       cmd_nack = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic       rsp_ready = 1'b0;
  logic       cmd_ready;
  logic       rsp_valid;
  logic       rsp_nack;
  logic [7:0] rsp_data;
  logic       busy;
  logic [7:0] mem_m [0:2047];
  logic [10:0] cnt_m;
  logic [10:0] pg;
  logic [8:0] r;
  int         n_errors = 0;
  int         check_count = 0;
  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;
  serp_link_if serp_link_if_i ();
  serp_ctl serp_ctl_i (
    .clk_sys(clk_sys), .rst(rst), .link(serp_link_if_i),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start),
    .cmd_stop(cmd_stop), .cmd_rd(cmd_rd), .cmd_nack(cmd_nack), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_nack(rsp_nack)
  );
  serp_dev #(.WR_CYC(WR_CYC), .DEV_CODE(DEV)) serp_dev_i (
    .clk_sys(clk_sys), .rst(rst), .link(serp_link_if_i), .wp(wp), .busy(busy)
  );
  serp_link_assertions #(.WR_CYC(WR_CYC)) serp_link_assertions_i (
    .clk_sys(clk_sys), .rst(rst), .scl_c_o(serp_link_if_i.scl_c_o),
    .sda_c_o(serp_link_if_i.sda_c_o), .sda_d_o(serp_link_if_i.sda_d_o),
    .sda_d_oe(serp_link_if_i.sda_d_oe), .scl(serp_link_if_i.scl),
    .sda(serp_link_if_i.sda), .wp(wp), .busy(busy)
  );
  // address byte: type code, page bits, direction
  function automatic logic [7:0] dev_byte(input logic [10:0] a, input logic rx);
    return {DEV, a[10:8], rx};
  endfunction
  // writes advance only the in-page offset
  function automatic logic [10:0] in_page(input logic [10:0] a, input int i);
    return {a[10:4], a[3:0] + 4'(i)};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %2h expected %2h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hold the command until the edge that takes it
  task automatic send(input logic st, sp, rx, nk, input logic [7:0] d);
    int k;
    @(posedge clk_sys);
    #1;
    {cmd_start, cmd_stop, cmd_rd, cmd_nack, cmd_data} = {st, sp, rx, nk, d};
    cmd_valid = 1'b1;
    for (k = 0; k < 4000 && cmd_ready !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    // a command that is never taken is a hang, not a silent skip
    if (k == 4000) begin
      n_errors++;
      $display("[ERR] t=%0t command not taken", $time);
    end
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
  endtask
  task automatic pop(output logic [8:0] q);
    int k;
    for (k = 0; k < 4000 && rsp_valid !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    // an answer that never comes counts as a mismatch
    if (k == 4000) begin
      n_errors++;
      $display("[ERR] t=%0t answer never came", $time);
    end
    q = {rsp_nack, rsp_data};
    rsp_ready = 1'b1;
    @(posedge clk_sys);
    #1;
    rsp_ready = 1'b0;
  endtask
  task automatic xfer(input logic st, sp, rx, nk, input logic [7:0] d, output logic [8:0] q);
    send(st, sp, rx, nk, d);
    pop(q);
  endtask
  // write n random bytes from address a, closed by stop
  task automatic wr_seq(input logic [10:0] a, input int n);
    logic [7:0] d;
    int i;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_byte(a, 1'b0), r);
    chk({7'h00, r[8]}, 8'h00);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, a[7:0], r);
    chk({7'h00, r[8]}, 8'h00);
    for (i = 0; i < n; i++) begin
      d = 8'($urandom());
      xfer(1'b0, i == n - 1, 1'b0, 1'b0, d, r);
      chk({7'h00, r[8]}, 8'h00);
      if (!wp)
        mem_m[in_page(a, i)] = d;
    end
  endtask
  // poll, then random or current read of n bytes; the last two are popped only after the refusal check
  task automatic rd_seq(input logic [10:0] a, input int n, input logic cur, input logic prog);
    logic [8:0] r2;
    int i;
    int polls;
    polls = 0;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_byte(a, cur), r);
    while (r[8] === 1'b1 && polls < 20) begin
      polls++;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_byte(a, cur), r);
    end
    chk({7'h00, r[8]}, 8'h00);
    chk({7'h00, polls > 0}, {7'h00, prog});
    if (!cur) begin
      xfer(1'b0, 1'b0, 1'b0, 1'b0, a[7:0], r);
      chk({7'h00, r[8]}, 8'h00);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, dev_byte(a, 1'b1), r);
      chk({7'h00, r[8]}, 8'h00);
    end
    for (i = 0; i < n - 2; i++) begin
      xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, r);
      chk(r[7:0], mem_m[11'(a + i)]);
    end
    send(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    send(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
    // two answers held: further commands must be refused, nothing lost
    repeat (300) @(posedge clk_sys);
    #1;
    chk({6'h00, cmd_ready, rsp_valid}, 8'h01);
    pop(r);
    // let an edge pass so the ready strobe is not driven twice at once
    @(posedge clk_sys);
    #1;
    pop(r2);
    chk(r[7:0], mem_m[11'(a + n - 2)]);
    chk(r2[7:0], mem_m[11'(a + n - 1)]);
    cnt_m = 11'(a + n);
  endtask
  initial begin
    void'($urandom(46755));
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (5) @(posedge clk_sys);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {DEV ^ 4'h1, 3'h0, 1'b0}, r);
    chk({7'h00, r[8]}, 8'h01);
    $display("test address mismatch done");
    // page write past the page end, starting near the boundary
    pg = 11'((1 + $urandom() % 126) * 16);
    wr_seq(pg + 11'h00C, 18);
    rd_seq(pg, 16, 1'b0, 1'b1);
    $display("test page write done");
    // reads wrap from the top of the array to address zero
    wr_seq(11'h7FE, 2);
    rd_seq(11'h7FE, 2, 1'b0, 1'b1);
    wr_seq(11'h000, 8);
    rd_seq(11'h7FE, 8, 1'b0, 1'b1);
    rd_seq(cnt_m, 2, 1'b1, 1'b0);
    $display("test read wrap done");
    wp = 1'b1;
    wr_seq(pg + 11'h003, 1);
    rd_seq(pg + 11'h002, 2, 1'b0, 1'b0);
    wp = 1'b0;
    $display("test write protect done");
    stop_test;
  end
  // cut a hang short well past the expected run length
  initial begin
    #240000;
    n_errors++;
    $display("[ERR] t=%0t watchdog expired", $time);
    stop_test;
  end
endmodule // serial_eeprom_rw_protocol_tb
`default_nettype wire
